// >>> design/acl_entry_mem.sv
`timescale 1ns/1ns
`default_nettype none
module acl_entry_mem #(
	parameter int ADDR_W = 4,
	parameter int BYTES = 16
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Access port
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [BYTES-1:0][7:0] wdata_i,
	input wire logic [BYTES-1:0] wmask_i,
	input wire logic write_i,
	input wire logic read_i,
	output logic [BYTES-1:0][7:0] rdata_o
);

	typedef struct packed {
		logic [(1<<ADDR_W)-1:0][BYTES-1:0][7:0] rows;
		logic [BYTES-1:0][7:0] rdata;
	} mem_state_t;

	mem_state_t ms;
	mem_state_t next_ms;

	// Read data held until the next read so the loader sees a stable word
	always_comb begin
		next_ms = ms;
		if (read_i) begin
			next_ms.rdata = ms.rows[addr_i];
		end
		for (int b = 0; b < BYTES; b++) begin
			if (write_i && wmask_i[b]) begin
				next_ms.rows[addr_i][b] = wdata_i[b];
			end
		end
	end

	// Table clears on reset, so unwritten entries read as no action
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			ms <= '0;
		end else begin
			ms <= next_ms;
		end
	end

	assign rdata_o = ms.rdata;

endmodule
`default_nettype wire

// >>> design/port_acl_access_ingress_ctrl.sv
// Chosen here: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module port_acl_access_ingress_ctrl #(
	parameter int PRIO_W = port_acl_pkg::PRIO_W
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Register port
	input wire logic [port_acl_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [7:0] reg_rdata_o,
	// Mirroring
	input wire logic rx_pkt_i,
	input wire logic tx_pkt_i,
	output logic rx_monitored_o,
	output logic tx_monitored_o,
	output logic monitor_port_o,
	// Priority classification
	input wire logic classify_i,
	input wire logic [port_acl_pkg::METHODS-1:0] method_valid_i,
	input wire logic [port_acl_pkg::METHODS-1:0][PRIO_W-1:0] method_prio_i,
	input wire logic [PRIO_W-1:0] default_prio_i,
	output logic [PRIO_W-1:0] result_prio_o,
	output logic result_valid_o,
	output logic [port_acl_pkg::METHODS-1:0] method_enable_o,
	// Staged entry and transfer state
	output var port_acl_pkg::filter_mode_t staged_mode_o,
	output logic xfer_busy_o
);

	localparam int NB = port_acl_pkg::STAGE_BYTES;
	localparam int NM = port_acl_pkg::METHODS;

	typedef struct packed {
		logic [NB-1:0][7:0] stage;
		logic [7:0] sel_high;
		logic [7:0] sel_low;
		logic dir_write;
		logic [port_acl_pkg::INDEX_W-1:0] rule_entry_index;
		logic wr_done;
		logic rd_done;
		port_acl_pkg::xfer_state_t xfer;
		logic rx_monitor;
		logic tx_monitor;
		logic monitor_port;
		logic [7:0] class_sel;
		logic [7:0] rdata;
		logic rx_marked;
		logic tx_marked;
		logic [PRIO_W-1:0] prio;
		logic prio_valid;
	} state_t;

	state_t st;
	state_t next_st;

	logic [2*8-1:0] sel_all;
	logic [NB-1:0] byte_sel;
	logic busy;
	logic [NB-1:0][7:0] mem_rdata;
	logic [NM-1:0] active;
	logic [PRIO_W-1:0] prio_max;
	logic [PRIO_W-1:0] prio_or;
	logic [PRIO_W-1:0] prio_first;
	logic found;
	logic [PRIO_W-1:0] class_prio;
	logic [7:0] read_value;
	logic [7:0] stage_wmask;
	logic in_stage;

	// Select registers count down the staging bytes: MSB of the pair is byte 0
	assign sel_all = {st.sel_high, st.sel_low};
	genvar k;
	generate
		for (k = 0; k < NB; k++) begin : g_sel
			assign byte_sel[k] = sel_all[NB-1-k];
		end
	endgenerate

	assign busy = (st.xfer != port_acl_pkg::XFER_IDLE);

	// Table write commits the selected staging bytes in one cycle
	acl_entry_mem #(
		.ADDR_W(port_acl_pkg::INDEX_W),
		.BYTES(NB)
	) u_entry_mem (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.addr_i(st.rule_entry_index),
		.wdata_i(st.stage),
		.wmask_i(byte_sel),
		.write_i(st.xfer == port_acl_pkg::XFER_WRITE),
		.read_i(st.xfer == port_acl_pkg::XFER_RD_ISSUE),
		.rdata_o(mem_rdata)
	);

	// Enabled methods that delivered a result for this packet
	assign active = method_valid_i & st.class_sel[NM-1:0];

	// Candidate priorities; the lowest select bit wins when no merge is asked
	always_comb begin
		prio_max = '0;
		prio_or = '0;
		prio_first = default_prio_i;
		found = 1'b0;
		for (int i = 0; i < NM; i++) begin
			if (active[i]) begin
				prio_or = prio_or | method_prio_i[i];
				if (method_prio_i[i] > prio_max) begin
					prio_max = method_prio_i[i];
				end
				if (!found) begin
					prio_first = method_prio_i[i];
					found = 1'b1;
				end
			end
		end
	end

	// Highest beats combine if software sets both against advice
	always_comb begin
		if (active == '0) begin
			class_prio = default_prio_i;
		end else if (st.class_sel[port_acl_pkg::CLASS_HIGHEST_BIT]) begin
			class_prio = prio_max;
		end else if (st.class_sel[port_acl_pkg::CLASS_COMBINE_BIT]) begin
			class_prio = prio_or;
		end else begin
			class_prio = prio_first;
		end
	end

	// Staging byte decode; byte 0 keeps its upper nibble at zero
	assign in_stage = (reg_addr_i[11:4] == port_acl_pkg::REG_STAGE_BASE[11:4]);
	assign stage_wmask = (reg_addr_i[3:0] == 4'h0) ?
		port_acl_pkg::FIRST_RULE_WMASK : 8'hFF;

	// Read multiplexer; unmapped offsets read zero
	always_comb begin
		read_value = 8'h00;
		if (in_stage) begin
			read_value = st.stage[reg_addr_i[3:0]];
		end else if (reg_addr_i == port_acl_pkg::REG_BYTE_SEL_HIGH) begin
			read_value = st.sel_high;
		end else if (reg_addr_i == port_acl_pkg::REG_BYTE_SEL_LOW) begin
			read_value = st.sel_low;
		end else if (reg_addr_i == port_acl_pkg::REG_XFER_CTRL) begin
			read_value[port_acl_pkg::XFER_WR_DONE_BIT] = st.wr_done;
			read_value[port_acl_pkg::XFER_RD_DONE_BIT] = st.rd_done;
			read_value[port_acl_pkg::XFER_DIR_BIT] = st.dir_write;
			read_value[3:0] = st.rule_entry_index;
		end else if (reg_addr_i == port_acl_pkg::REG_MON_CTRL) begin
			read_value[port_acl_pkg::MON_RX_BIT] = st.rx_monitor;
			read_value[port_acl_pkg::MON_TX_BIT] = st.tx_monitor;
			read_value[port_acl_pkg::MON_PORT_BIT] = st.monitor_port;
		end else if (reg_addr_i == port_acl_pkg::REG_CLASS_SEL) begin
			read_value = st.class_sel;
		end
	end

	// Next state: datapath pulses, transfer sequencer, then register writes
	always_comb begin
		next_st = st;
		next_st.rx_marked = rx_pkt_i & st.rx_monitor;
		next_st.tx_marked = tx_pkt_i & st.tx_monitor;
		next_st.prio_valid = classify_i;
		if (classify_i) begin
			next_st.prio = class_prio;
		end
		next_st.rdata = 8'h00;
		if (reg_read_i) begin
			next_st.rdata = read_value;
		end
		case (st.xfer)
			port_acl_pkg::XFER_WRITE: begin
				next_st.wr_done = 1'b1;
				next_st.xfer = port_acl_pkg::XFER_IDLE;
			end
			port_acl_pkg::XFER_RD_ISSUE: begin
				next_st.xfer = port_acl_pkg::XFER_RD_LOAD;
			end
			port_acl_pkg::XFER_RD_LOAD: begin
				// Unselected bytes keep whatever software staged there
				for (int b = 0; b < NB; b++) begin
					if (byte_sel[b]) begin
						next_st.stage[b] = (b == 0) ?
							(mem_rdata[b] & port_acl_pkg::FIRST_RULE_WMASK) :
							mem_rdata[b];
					end
				end
				next_st.rd_done = 1'b1;
				next_st.xfer = port_acl_pkg::XFER_IDLE;
			end
			default: begin
				next_st.xfer = st.xfer;
			end
		endcase
		// Transfer setup is frozen while busy, so a start can never race a set
		if (reg_write_i) begin
			if (in_stage) begin
				if (!busy) begin
					next_st.stage[reg_addr_i[3:0]] = reg_wdata_i & stage_wmask;
				end
			end else if (reg_addr_i == port_acl_pkg::REG_BYTE_SEL_HIGH) begin
				if (!busy) begin
					next_st.sel_high = reg_wdata_i;
				end
			end else if (reg_addr_i == port_acl_pkg::REG_BYTE_SEL_LOW) begin
				if (!busy) begin
					next_st.sel_low = reg_wdata_i;
					if (st.dir_write) begin
						next_st.wr_done = 1'b0;
						next_st.xfer = port_acl_pkg::XFER_WRITE;
					end else begin
						next_st.rd_done = 1'b0;
						next_st.xfer = port_acl_pkg::XFER_RD_ISSUE;
					end
				end
			end else if (reg_addr_i == port_acl_pkg::REG_XFER_CTRL) begin
				if (!busy) begin
					next_st.dir_write = reg_wdata_i[port_acl_pkg::XFER_DIR_BIT];
					next_st.rule_entry_index = reg_wdata_i[3:0];
				end
			end else if (reg_addr_i == port_acl_pkg::REG_MON_CTRL) begin
				next_st.rx_monitor = reg_wdata_i[port_acl_pkg::MON_RX_BIT];
				next_st.tx_monitor = reg_wdata_i[port_acl_pkg::MON_TX_BIT];
				next_st.monitor_port = reg_wdata_i[port_acl_pkg::MON_PORT_BIT];
			end else if (reg_addr_i == port_acl_pkg::REG_CLASS_SEL) begin
				next_st.class_sel = reg_wdata_i & port_acl_pkg::CLASS_WMASK;
			end
		end
	end

	// State register with synchronous reset
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			st <= '0;
			st.wr_done <= port_acl_pkg::RST_WR_DONE;
			st.rd_done <= port_acl_pkg::RST_RD_DONE;
			st.xfer <= port_acl_pkg::XFER_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// Outputs
	assign reg_rdata_o = st.rdata;
	assign rx_monitored_o = st.rx_marked;
	assign tx_monitored_o = st.tx_marked;
	assign monitor_port_o = st.monitor_port;
	assign result_prio_o = st.prio;
	assign result_valid_o = st.prio_valid;
	assign method_enable_o = st.class_sel[NM-1:0];
	assign staged_mode_o = port_acl_pkg::filter_mode_t'(
		st.stage[port_acl_pkg::MODE_BYTE][port_acl_pkg::MODE_LSB +: 2]);
	assign xfer_busy_o = busy;

	// Checks on the design's own outputs and state
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!resetn_i);

	logic start_hit;
	assign start_hit = reg_write_i && !busy &&
		(reg_addr_i == port_acl_pkg::REG_BYTE_SEL_LOW);

	a_write_status_cycle: assert property (
		start_hit && st.dir_write |=> !st.wr_done ##1 st.wr_done)
		else $error("write status not low for exactly one cycle");

	a_read_status_cycle: assert property (
		start_hit && !st.dir_write |=> !st.rd_done [*2] ##1 st.rd_done)
		else $error("read status not low for exactly two cycles");

	a_status_readback: assert property (
		reg_read_i && reg_addr_i == port_acl_pkg::REG_XFER_CTRL |=>
		reg_rdata_o[6] == $past(st.wr_done) && reg_rdata_o[5] == $past(st.rd_done))
		else $error("status readback mismatch");

	a_skip_unselected: assert property (
		st.xfer == port_acl_pkg::XFER_RD_LOAD && !byte_sel[3] |=>
		st.stage[3] == $past(st.stage[3]))
		else $error("unselected byte changed on table read");

	a_low_map: assert property (
		st.xfer == port_acl_pkg::XFER_RD_LOAD && st.sel_low[0] |=>
		st.stage[15] == $past(mem_rdata[15]))
		else $error("low select bit 0 did not load byte F");

	a_high_map: assert property (
		st.xfer == port_acl_pkg::XFER_RD_LOAD && st.sel_high[0] |=>
		st.stage[7] == $past(mem_rdata[7]))
		else $error("high select bit 0 did not load byte 7");

	a_rx_marking: assert property (
		rx_pkt_i && st.rx_monitor |=> rx_monitored_o)
		else $error("received packet not marked");

	a_tx_marking: assert property (
		tx_pkt_i && !st.tx_monitor |=> !tx_monitored_o)
		else $error("transmitted packet marked without enable");

	a_monitor_port: assert property (
		reg_write_i && reg_addr_i == port_acl_pkg::REG_MON_CTRL |=>
		monitor_port_o == $past(reg_wdata_i[1]))
		else $error("monitor port bit not applied");

	a_highest_pick: assert property (
		classify_i && st.class_sel[7] && active[0] |=>
		result_valid_o && result_prio_o >= $past(method_prio_i[0]))
		else $error("highest priority below a candidate");

	a_combine_or: assert property (
		classify_i && !st.class_sel[7] && st.class_sel[6] && active[1] |=>
		(result_prio_o & $past(method_prio_i[1])) == $past(method_prio_i[1]))
		else $error("combined priority misses a candidate bit");

	a_all_disabled: assert property (
		classify_i && st.class_sel[4:0] == 5'h00 |=>
		result_prio_o == $past(default_prio_i))
		else $error("disabled methods changed the priority");

	c_table_write: cover property (start_hit && st.dir_write ##2 st.wr_done);
	c_table_read: cover property (start_hit && !st.dir_write ##3 st.rd_done);
	c_rx_marked: cover property (rx_monitored_o);
	c_combine: cover property (classify_i && st.class_sel[6] && active[1]);

endmodule
`default_nettype wire

// >>> design/port_acl_pkg.sv
package port_acl_pkg;

	// Register port geometry
	localparam int ADDR_W = 12;
	localparam int STAGE_BYTES = 16;
	localparam int INDEX_W = 4;
	localparam int PRIO_W = 3;
	localparam int METHODS = 5;

	// Register offsets within one port's window
	localparam logic [ADDR_W-1:0] REG_STAGE_BASE = 12'h600;
	localparam logic [ADDR_W-1:0] REG_RULESET_LOW = 12'h60F;
	localparam logic [ADDR_W-1:0] REG_BYTE_SEL_HIGH = 12'h610;
	localparam logic [ADDR_W-1:0] REG_BYTE_SEL_LOW = 12'h611;
	localparam logic [ADDR_W-1:0] REG_XFER_CTRL = 12'h612;
	localparam logic [ADDR_W-1:0] REG_MON_CTRL = 12'h800;
	localparam logic [ADDR_W-1:0] REG_CLASS_SEL = 12'h801;

	// Transfer control fields
	localparam int XFER_WR_DONE_BIT = 6;
	localparam int XFER_RD_DONE_BIT = 5;
	localparam int XFER_DIR_BIT = 4;
	localparam int XFER_INDEX_LSB = 0;

	// Mirroring control fields
	localparam int MON_RX_BIT = 6;
	localparam int MON_TX_BIT = 5;
	localparam int MON_PORT_BIT = 1;

	// Classification select fields
	localparam int CLASS_HIGHEST_BIT = 7;
	localparam int CLASS_COMBINE_BIT = 6;
	localparam int CLASS_MAC_BIT = 4;
	localparam int CLASS_VLAN_BIT = 3;
	localparam int CLASS_TAG_BIT = 2;
	localparam int CLASS_DSV_BIT = 1;
	localparam int CLASS_ACL_BIT = 0;
	localparam logic [7:0] CLASS_WMASK = 8'hDF;

	// Staged entry layout
	localparam int MODE_BYTE = 1;
	localparam int MODE_LSB = 4;
	localparam logic [7:0] FIRST_RULE_WMASK = 8'h0F;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic RST_WR_DONE = 1'b1;
	localparam logic RST_RD_DONE = 1'b1;

	typedef enum logic [1:0] {
		XFER_IDLE,
		XFER_WRITE,
		XFER_RD_ISSUE,
		XFER_RD_LOAD
	} xfer_state_t;

	// No action, L2 MAC, L3 IP, L4 port or protocol
	typedef enum logic [1:0] {
		MODE_NONE,
		MODE_L2_MAC,
		MODE_L3_IP,
		MODE_L4_PORT
	} filter_mode_t;

endpackage

// >>> test/port_acl_access_ingress_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module port_acl_access_ingress_ctrl_tb;
	// Short register aliases
	localparam logic [11:0] A_STG = port_acl_pkg::REG_STAGE_BASE;
	localparam logic [11:0] A_RSL = port_acl_pkg::REG_RULESET_LOW;
	localparam logic [11:0] A_SH = port_acl_pkg::REG_BYTE_SEL_HIGH;
	localparam logic [11:0] A_SL = port_acl_pkg::REG_BYTE_SEL_LOW;
	localparam logic [11:0] A_CTL = port_acl_pkg::REG_XFER_CTRL;
	localparam logic [11:0] A_MON = port_acl_pkg::REG_MON_CTRL;
	localparam logic [11:0] A_CLS = port_acl_pkg::REG_CLASS_SEL;
	localparam logic [11:0] A_BAD = 12'h700;
	// Design ports
	logic mclk_i;
	logic resetn_i;
	logic [11:0] reg_addr_i;
	logic [7:0] reg_wdata_i;
	logic reg_write_i;
	logic reg_read_i;
	logic [7:0] reg_rdata_o;
	logic rx_pkt_i;
	logic tx_pkt_i;
	logic rx_monitored_o;
	logic tx_monitored_o;
	logic monitor_port_o;
	logic classify_i;
	logic [4:0] method_valid_i;
	logic [4:0][2:0] method_prio_i;
	logic [2:0] default_prio_i;
	logic [2:0] result_prio_o;
	logic result_valid_o;
	logic [4:0] method_enable_o;
	port_acl_pkg::filter_mode_t staged_mode_o;
	logic xfer_busy_o;
	// Bench state
	int miscompares;
	int total_checks;
	logic [7:0] rdat;
	logic [7:0] exp_st [16];
	logic [2:0] exp_p [5];

	port_acl_access_ingress_ctrl u_port_acl_access_ingress_ctrl (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_write_i(reg_write_i),
		.reg_read_i(reg_read_i),
		.reg_rdata_o(reg_rdata_o),
		.rx_pkt_i(rx_pkt_i),
		.tx_pkt_i(tx_pkt_i),
		.rx_monitored_o(rx_monitored_o),
		.tx_monitored_o(tx_monitored_o),
		.monitor_port_o(monitor_port_o),
		.classify_i(classify_i),
		.method_valid_i(method_valid_i),
		.method_prio_i(method_prio_i),
		.default_prio_i(default_prio_i),
		.result_prio_o(result_prio_o),
		.result_valid_o(result_valid_o),
		.method_enable_o(method_enable_o),
		.staged_mode_o(staged_mode_o),
		.xfer_busy_o(xfer_busy_o)
	);

	// 100 MHz clock
	initial begin
		mclk_i = 1'h0;
		forever #5 mclk_i = ~mclk_i;
	end

	// Staging pattern, distinct per byte
	function automatic logic [7:0] pat(input int k);
		return {4'(15 - k), 4'(k)};
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results();
		if (miscompares == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_write_i <= 1'h1;
		@(posedge mclk_i);
		reg_write_i <= 1'h0;
		// Step off the edge so callers see the state this write launched
		#1;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [11:0] a);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_read_i <= 1'h1;
		@(posedge mclk_i);
		reg_read_i <= 1'h0;
		#1;
		rdat = reg_rdata_o;
	endtask

	// Start a transfer, then read status straight away while it runs
	task automatic xfer(input logic dir, input logic [3:0] idx,
		input logic [7:0] hi, input logic [7:0] lo);
		int n;
		wr(A_SH, hi);
		wr(A_CTL, {3'h0, dir, idx});
		@(posedge mclk_i);
		reg_addr_i <= A_SL;
		reg_wdata_i <= lo;
		reg_write_i <= 1'h1;
		@(posedge mclk_i);
		reg_write_i <= 1'h0;
		reg_read_i <= 1'h1;
		reg_addr_i <= A_CTL;
		#1;
		chk({7'h0, xfer_busy_o}, 8'h01);
		@(posedge mclk_i);
		reg_read_i <= 1'h0;
		#1;
		chk(reg_rdata_o, {1'h0, ~dir, dir, dir, idx});
		n = 0;
		while (xfer_busy_o !== 1'h0 && n < 20) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		if (xfer_busy_o !== 1'h0) begin
			miscompares++;
			results();
		end
		rd(A_CTL);
		chk(rdat, {3'h3, dir, idx});
	endtask

	task automatic clear_stage();
		for (int k = 0; k < 16; k++) begin
			wr(A_STG + 12'(k), 8'h00);
			exp_st[k] = 8'h00;
		end
	endtask

	task automatic check_stage();
		for (int k = 0; k < 16; k++) begin
			rd(A_STG + 12'(k));
			chk(rdat, exp_st[k]);
		end
	endtask

	task automatic pkt(input logic rx, input logic tx,
		input logic erx, input logic etx);
		@(posedge mclk_i);
		rx_pkt_i <= rx;
		tx_pkt_i <= tx;
		@(posedge mclk_i);
		rx_pkt_i <= 1'h0;
		tx_pkt_i <= 1'h0;
		#1;
		chk({6'h0, rx_monitored_o, tx_monitored_o}, {6'h0, erx, etx});
	endtask

	task automatic classify(input logic [2:0] e);
		@(posedge mclk_i);
		classify_i <= 1'h1;
		@(posedge mclk_i);
		classify_i <= 1'h0;
		#1;
		chk({7'h0, result_valid_o}, 8'h01);
		chk({5'h0, result_prio_o}, {5'h0, e});
	endtask

	// Main sequence
	initial begin
		miscompares = 0;
		total_checks = 0;
		resetn_i = 1'h0;
		reg_addr_i = 12'h000;
		reg_wdata_i = 8'h00;
		reg_write_i = 1'h0;
		reg_read_i = 1'h0;
		rx_pkt_i = 1'h0;
		tx_pkt_i = 1'h0;
		classify_i = 1'h0;
		method_valid_i = 5'h1F;
		method_prio_i = {3'h5, 3'h3, 3'h4, 3'h2, 3'h1};
		default_prio_i = 3'h6;
		exp_p = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h5};
		repeat (3) @(posedge mclk_i);
		resetn_i <= 1'h1;
		// Reset values and plain register access
		rd(A_CTL);
		chk(rdat, 8'h60);
		rd(A_SL);
		chk(rdat, 8'h00);
		rd(A_CLS);
		chk(rdat, 8'h00);
		wr(A_RSL, 8'hA5);
		rd(A_RSL);
		chk(rdat, 8'hA5);
		wr(A_BAD, 8'hFF);
		rd(A_BAD);
		chk(rdat, 8'h00);
		// Status bits are read-only; setup bits are not a start
		wr(A_CTL, 8'hFF);
		rd(A_CTL);
		chk(rdat, 8'h7F);
		chk({7'h0, xfer_busy_o}, 8'h00);
		// Mirroring: receive and transmit apart, then together
		// Switch-wide mirroring setup lives outside this block
		wr(A_MON, 8'h40);
		pkt(1'h1, 1'h1, 1'h1, 1'h0);
		wr(A_MON, 8'h20);
		pkt(1'h1, 1'h1, 1'h0, 1'h1);
		wr(A_MON, 8'hFF);
		rd(A_MON);
		chk(rdat, 8'h62);
		chk({7'h0, monitor_port_o}, 8'h01);
		pkt(1'h1, 1'h0, 1'h1, 1'h0);
		pkt(1'h0, 1'h1, 1'h0, 1'h1);
		wr(A_MON, 8'h00);
		pkt(1'h1, 1'h1, 1'h0, 1'h0);
		chk({7'h0, monitor_port_o}, 8'h00);
		// Classification: nothing enabled falls back to the default
		classify(3'h6);
		for (int b = 0; b < 5; b++) begin
			wr(A_CLS, 8'(1 << b));
			chk({3'h0, method_enable_o}, 8'(1 << b));
			classify(exp_p[b]);
		end
		wr(A_CLS, 8'h9F);
		classify(3'h5);
		wr(A_CLS, 8'h5F);
		classify(3'h7);
		wr(A_CLS, 8'hFF);
		rd(A_CLS);
		chk(rdat, 8'hDF);
		classify(3'h5);
		// Invalid results are passed over
		wr(A_CLS, 8'h1F);
		@(posedge mclk_i);
		method_valid_i <= 5'h0C;
		classify(3'h4);
		// Filter mode field of staged byte 1
		for (int m = 0; m < 4; m++) begin
			wr(A_STG + 12'h001, 8'(m << 4));
			chk(8'(staged_mode_o), 8'(m));
		end
		// Fill staging, write it all to entry 3
		for (int k = 0; k < 16; k++) begin
			wr(A_STG + 12'(k), pat(k));
			exp_st[k] = (k == 0) ? 8'h00 : pat(k);
		end
		check_stage();
		xfer(1'h1, 4'h3, 8'hFF, 8'hFF);
		// Reads of one byte per select register land at the mapped places only
		clear_stage();
		xfer(1'h0, 4'h3, 8'h01, 8'h01);
		exp_st[7] = pat(7);
		exp_st[15] = pat(15);
		check_stage();
		xfer(1'h0, 4'h3, 8'h40, 8'h80);
		exp_st[1] = pat(1);
		exp_st[8] = pat(8);
		check_stage();
		// A write of one byte leaves the rest of the entry alone
		for (int k = 0; k < 16; k++) begin
			wr(A_STG + 12'(k), 8'h5A);
		end
		xfer(1'h1, 4'h3, 8'h00, 8'h01);
		clear_stage();
		xfer(1'h0, 4'h3, 8'hFF, 8'hFF);
		for (int k = 1; k < 15; k++) begin
			exp_st[k] = pat(k);
		end
		exp_st[15] = 8'h5A;
		check_stage();
		// A different index reaches an untouched entry
		xfer(1'h0, 4'h5, 8'hFF, 8'hFF);
		for (int k = 0; k < 16; k++) begin
			exp_st[k] = 8'h00;
		end
		check_stage();
		results();
	end
endmodule
`default_nettype wire
